// >>> rtl/dcpsp_slave.sv
// Serial slave port of a dual digital potentiometer
module dcpsp_slave
	import dcpsp_pkg::*;
#(
	parameter int NV_WRITE_CYCLES = NVWRITE_CYC
)(
	// Clock, reset, enable
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       clkEn,
	// Serial link pins
	input  wire logic       sck,
	input  wire logic       csN,
	input  wire logic       sdi,
	output logic            sdoOut,
	output logic            sdoOeN,
	// Potentiometer state
	output logic [7:0]      wiper0,
	output logic [7:0]      wiper1,
	output logic            shutdownActive,
	output logic            standby,
	output logic            writeBusy
);
	// Refuse a write cycle count the busy counter cannot serve
	if (NV_WRITE_CYCLES < 1) begin : g_bad_cycles
		$error("NV_WRITE_CYCLES must be at least one");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CMD  = 3'b010,
		ST_DATA = 3'b100
	} dcpsp_state_t;

	typedef struct packed {
		logic [1:0]   sckSync;
		logic [1:0]   csSync;
		logic [1:0]   sdiSync;
		logic         sckPrev;
		logic         csPrev;
		logic         armed;
		dcpsp_state_t state;
		logic [2:0]   bitCnt;
		logic [7:0]   shiftIn;
		logic [7:0]   shiftOut;
		logic [2:0]   opcode;
		logic [4:0]   addr;
		logic [7:0]   wrData;
		logic         wrPend;
		logic [7:0]   wiper0;
		logic [7:0]   wiper1;
		logic         volatile_select_bit;
		logic         shdnN;
		logic         odMode;
		logic [31:0]  busyCnt;
		logic         sdo;
	} dcpsp_reg_t;

	dcpsp_reg_t  r_ff, nxt_r;
	dcpsp_nv_if  nv ();

	dcpsp_nv_mem u_nv (
		.mclk  (mclk),
		.rstn  (rstn),
		.clkEn (clkEn),
		.nv    (nv)
	);

	// Value the device presents for a register address
	function automatic logic [7:0] readValue(input dcpsp_reg_t s, input logic [7:0] nvData);
		logic [7:0] v;
		v = 8'h00;
		if (s.addr == ADDR_ACR) begin
			v[ACR_VOL]  = s.volatile_select_bit;
			v[ACR_SHUTDOWN_N_BIT] = s.shdnN;
			v[ACR_WIP]  = (s.busyCnt != 32'h0);
			v[ACR_OUT]  = s.odMode;
		end else if (s.addr == ADDR_WIPER0 && s.volatile_select_bit) begin
			v = s.wiper0;
		end else if (s.addr == ADDR_WIPER1 && s.volatile_select_bit) begin
			v = s.wiper1;
		end else if (s.addr[4] == 1'b0 && s.addr != ADDR_RSVD) begin
			v = nvData;
		end
		return v;
	endfunction : readValue

	////////////////////////////////////////////////////////////////////////
	logic       sckRise;
	logic       sckFall;
	logic       csLow;
	logic       csRise;
	logic       busy;
	logic       nvWrite;
	logic [7:0] rdVal;

	always_comb begin
		nxt_r   = r_ff;
		nvWrite = 1'b0;
		nxt_r.sckSync = {r_ff.sckSync[0], sck};
		nxt_r.csSync  = {r_ff.csSync[0], csN};
		nxt_r.sdiSync = {r_ff.sdiSync[0], sdi};
		nxt_r.sckPrev = r_ff.sckSync[1];
		nxt_r.csPrev  = r_ff.csSync[1];
		sckRise = r_ff.sckSync[1] & ~r_ff.sckPrev;
		sckFall = ~r_ff.sckSync[1] & r_ff.sckPrev;
		csLow   = ~r_ff.csSync[1];
		csRise  = r_ff.csSync[1] & ~r_ff.csPrev;
		busy    = (r_ff.busyCnt != 32'h0);
		rdVal   = readValue(r_ff, nv.rdData);

		if (busy)
			nxt_r.busyCnt = r_ff.busyCnt - 32'h1;

		// Nothing counts until the first select falling edge
		if (!r_ff.csSync[1] && r_ff.csPrev)
			nxt_r.armed = 1'b1;

		if (!csLow || !r_ff.armed) begin
			nxt_r.state  = ST_IDLE;
			nxt_r.bitCnt = 3'h0;
			// Next frame starts low, so open drain drives in the opcode byte
			nxt_r.sdo    = 1'b0;
		end else begin
			if (r_ff.state == ST_IDLE)
				nxt_r.state = ST_CMD;
			if (sckRise) begin
				nxt_r.shiftIn = {r_ff.shiftIn[6:0], r_ff.sdiSync[1]};
				nxt_r.bitCnt  = r_ff.bitCnt + 3'h1;
				if (r_ff.bitCnt == 3'h7) begin
					unique case (nxt_r.state)
						ST_CMD: begin
							nxt_r.opcode = nxt_r.shiftIn[INSTR_MSB:INSTR_LSB];
							nxt_r.addr   = nxt_r.shiftIn[ADDR_MSB:ADDR_LSB];
							nxt_r.state  = ST_DATA;
						end
						ST_DATA: begin
							if (r_ff.opcode == OP_WRITE) begin
								nxt_r.wrData = nxt_r.shiftIn;
								nxt_r.wrPend = 1'b1;
							end
						end
						default: nxt_r.state = ST_IDLE;
					endcase
				end
			end
			if (sckFall) begin
				if (r_ff.state == ST_DATA && r_ff.bitCnt == 3'h0)
					nxt_r.shiftOut = rdVal;
				else
					nxt_r.shiftOut = {r_ff.shiftOut[6:0], 1'b0};
				if (r_ff.state == ST_DATA && r_ff.opcode == OP_READ) begin
					nxt_r.sdo = (r_ff.bitCnt == 3'h0) ? rdVal[7] : r_ff.shiftOut[6];
				end else begin
					nxt_r.sdo = 1'b0;
				end
			end
		end

		// Commit the last full write byte when select rises
		if (csRise && r_ff.wrPend) begin
			nxt_r.wrPend = 1'b0;
			if (r_ff.addr == ADDR_ACR && !busy) begin
				nxt_r.volatile_select_bit    = r_ff.wrData[ACR_VOL];
				nxt_r.shdnN  = r_ff.wrData[ACR_SHUTDOWN_N_BIT];
				nxt_r.odMode = r_ff.wrData[ACR_OUT];
			end else if (!busy && (r_ff.addr == ADDR_WIPER0 || r_ff.addr == ADDR_WIPER1)) begin
				if (r_ff.addr[0])
					nxt_r.wiper1 = r_ff.wrData;
				else
					nxt_r.wiper0 = r_ff.wrData;
				if (!r_ff.volatile_select_bit) begin
					nvWrite       = 1'b1;
					nxt_r.busyCnt = 32'(NV_WRITE_CYCLES);
				end
			end else if (!busy && !r_ff.volatile_select_bit && r_ff.addr >= 5'(GP_FIRST)
				&& r_ff.addr <= 5'(GP_LAST)) begin
				nvWrite       = 1'b1;
				nxt_r.busyCnt = 32'(NV_WRITE_CYCLES);
			end
		end
	end

	assign nv.wrEn   = nvWrite;
	assign nv.wrAddr = r_ff.addr[3:0];
	assign nv.wrData = r_ff.wrData;
	assign nv.rdAddr = r_ff.addr[3:0];

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			r_ff <= '{sckSync: 2'h0, csSync: 2'h3, sdiSync: 2'h0, sckPrev: 1'b0,
				csPrev: 1'b1, armed: 1'b0, state: ST_IDLE, bitCnt: 3'h0,
				shiftIn: 8'h00, shiftOut: 8'h00, opcode: 3'h0, addr: 5'h00,
				wrData: 8'h00, wrPend: 1'b0, wiper0: WIPER_RESET,
				wiper1: WIPER_RESET, volatile_select_bit: VOL_RESET, shdnN: SHUTDOWN_N_BIT_RESET,
				odMode: OUT_RESET, busyCnt: 32'h0, sdo: 1'b0};
		end else if (clkEn) begin
			r_ff <= nxt_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Enable low drives; open drain only pulls zeros down
	always_comb begin
		sdoOut = r_ff.sdo;
		if (!(~r_ff.csSync[1] && r_ff.armed))
			sdoOeN = 1'b1;
		else if (r_ff.odMode)
			sdoOeN = r_ff.sdo;
		else
			sdoOeN = 1'b0;
	end

	assign wiper0         = r_ff.wiper0;
	assign wiper1         = r_ff.wiper1;
	assign shutdownActive = ~r_ff.shdnN;
	assign writeBusy      = (r_ff.busyCnt != 32'h0);
	assign standby        = r_ff.csSync[1] && (r_ff.busyCnt == 32'h0);
endmodule : dcpsp_slave

// >>> rtl/dcpsp_pkg.sv
// Package of constants for the potentiometer serial slave port
package dcpsp_pkg;
	// Instruction byte fields
	localparam int INSTR_MSB    = 7;
	localparam int INSTR_LSB    = 5;
	localparam int ADDR_MSB     = 4;
	localparam int ADDR_LSB     = 0;
	// Instruction codes
	localparam logic [2:0] OP_READ  = 3'h3;
	localparam logic [2:0] OP_WRITE = 3'h2;
	// Register addresses
	localparam logic [4:0] ADDR_WIPER0 = 5'h00;
	localparam logic [4:0] ADDR_WIPER1 = 5'h01;
	localparam logic [4:0] ADDR_RSVD   = 5'h0f;
	localparam logic [4:0] ADDR_ACR    = 5'h10;
	localparam int GP_FIRST = 2;
	localparam int GP_LAST  = 14;
	// Access control field positions
	localparam int ACR_VOL  = 7;
	localparam int ACR_SHUTDOWN_N_BIT = 6;
	localparam int ACR_WIP  = 5;
	localparam int ACR_OUT  = 1;
	// Reset values
	localparam logic [7:0] WIPER_RESET = 8'h80;
	localparam logic [7:0] NV_RESET    = 8'h80;
	localparam logic       VOL_RESET   = 1'b0;
	localparam logic       SHUTDOWN_N_BIT_RESET  = 1'b1;
	localparam logic       OUT_RESET   = 1'b0;
	// Timing and store depth
	localparam int CLK_HZ       = 25_000_000;
	localparam int NVWRITE_MS   = 20;
	localparam int NVWRITE_CYC  = CLK_HZ / 1000 * NVWRITE_MS;
	localparam int NV_DEPTH     = 16;
endpackage : dcpsp_pkg

// >>> rtl/dcpsp_nv_if.sv
// Interface between the port logic and its non-volatile store
interface dcpsp_nv_if;
	logic       wrEn;
	logic [3:0] wrAddr;
	logic [7:0] wrData;
	logic [3:0] rdAddr;
	logic [7:0] rdData;
	modport port (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
	modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : dcpsp_nv_if

// >>> rtl/dcpsp_nv_mem.sv
// Small store modelling the non-volatile registers
module dcpsp_nv_mem
	import dcpsp_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic clkEn,
	// Access
	dcpsp_nv_if.mem   nv
);
	typedef struct packed {
		logic [NV_DEPTH-1:0][7:0] cells;
		logic [7:0]               rd;
	} dcpsp_mem_t;
	dcpsp_mem_t st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (nv.wrEn)
			nxt_st.cells[nv.wrAddr] = nv.wrData;
		nxt_st.rd = st_ff.cells[nv.rdAddr];
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st_ff <= '{cells: {NV_DEPTH{NV_RESET}}, rd: 8'h00};
		end else if (clkEn) begin
			st_ff <= nxt_st;
		end
	end

	assign nv.rdData = st_ff.rd;
endmodule : dcpsp_nv_mem

// >>> tb/dcpsp_slave_monitor.sv
// Concurrent checks on the slave port pins
module dcpsp_slave_monitor #(
	parameter int NV_WRITE_CYCLES = 50
)(
	// Clock and reset
	input wire logic       mclk,
	input wire logic       rstn,
	// Link pins
	input wire logic       sck,
	input wire logic       csN,
	input wire logic       sdoOut,
	input wire logic       sdoOeN,
	// State
	input wire logic [7:0] wiper0,
	input wire logic [7:0] wiper1,
	input wire logic       shutdownActive,
	input wire logic       standby,
	input wire logic       writeBusy
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BUSY_MAX = NV_WRITE_CYCLES + 2;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	AST_DESEL_HIZ: assert property (csN[*5] |-> sdoOeN)
		else $error("sdo driven while deselected");
	AST_SEL_DRIVE: assert property ($fell(csN) |-> ##[2:5] !sdoOeN)
		else $error("sdo not enabled after select");
	AST_SEL_ACTIVE: assert property (!csN[*5] |-> !standby)
		else $error("standby while selected");
	AST_BUSY_AWAKE: assert property (writeBusy |-> !standby)
		else $error("standby during write cycle");
	AST_IDLE_SLEEP: assert property (csN[*8] ##0 !writeBusy |-> standby)
		else $error("no standby while idle");
	AST_FALL_SHIFT: assert property ($changed(sdoOut) |-> !$past(sck, 2))
		else $error("sdo moved outside falling edge");
	AST_COMMIT_W0: assert property ($changed(wiper0) |-> $past(csN, 2))
		else $error("wiper0 moved inside frame");
	AST_COMMIT_W1: assert property ($changed(wiper1) |-> $past(csN, 2))
		else $error("wiper1 moved inside frame");
	AST_COMMIT_SD: assert property ($changed(shutdownActive) |-> $past(csN, 2))
		else $error("shutdown moved inside frame");
	AST_BUSY_END: assert property ($rose(writeBusy) |-> ##[1:BUSY_MAX] $fell(writeBusy))
		else $error("write cycle too long");
endmodule : dcpsp_slave_monitor
bind dcpsp_slave dcpsp_slave_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) dcpsp_slave_monitor_i (
	.mclk, .rstn, .sck, .csN, .sdoOut, .sdoOeN, .wiper0, .wiper1,
	.shutdownActive, .standby, .writeBusy);

// >>> tb/dcpsp_host.sv
// Serial host model driving the slave port link
module dcpsp_host (
	// Clock
	input wire logic mclk,
	// Link
	output logic     sck,
	output logic     csN,
	output logic     sdi,
	input wire logic sdoOut,
	input wire logic sdoOeN
);
	timeunit 1ns;
	timeprecision 1ns;
	int hiCnt = 0;
	// Pull-up holds the released line high
	wire logic sdoLine = sdoOeN | sdoOut;
	initial begin
		sck = 1'h0;
		csN = 1'h1;
		sdi = 1'h0;
	end
	always @(posedge mclk) if (!sdoOeN && sdoOut) hiCnt++;
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	// Mode 0, 320 ns bit time; clock idles low between frames
	task automatic frame(input logic [15:0] tx, output logic [7:0] rx);
		cyc(52);
		csN = 1'h0;
		cyc(8);
		for (int i = 15; i >= 0; i--) begin
			sdi = tx[i];
			cyc(4);
			sck = 1'h1;
			rx = {rx[6:0], sdoLine};
			cyc(4);
			sck = 1'h0;
		end
		cyc(8);
		csN = 1'h1;
		sdi = ~sdi;
		cyc(4);
	endtask : frame
endmodule : dcpsp_host

// >>> tb/potentiometer_spi_slave_port_tb_top.sv
// Self-checking bench of the potentiometer serial slave port
module potentiometer_spi_slave_port_tb_top
	import dcpsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Long enough to read the busy flag and try a write inside one cycle
	localparam int NVC = 600;
	logic mclk = 1'h0;
	logic rstn = 1'h0;
	wire logic sck, csN, sdi, sdoOut, sdoOeN, shutdownActive, standby, writeBusy;
	wire logic [7:0] wiper0, wiper1;
	logic [7:0] rx, v, gpData;
	logic [4:0] gpAddr;
	logic [7:0] tbl [3];
	int fails = 0;
	int n_checks = 0;
	int h0;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
	always #20 mclk = ~mclk;
	dcpsp_slave #(.NV_WRITE_CYCLES(NVC)) dcpsp_slave_i (.mclk, .rstn, .clkEn(1'h1), .sck,
		.csN, .sdi, .sdoOut, .sdoOeN, .wiper0, .wiper1, .shutdownActive, .standby, .writeBusy);
	dcpsp_host dcpsp_host_i (.mclk, .sck, .csN, .sdi, .sdoOut, .sdoOeN);
	function automatic logic [7:0] access_control_reg(input logic volatile_select_bit, shutdown_n_bit, od);
		return {volatile_select_bit, shutdown_n_bit, 4'h0, od, 1'h0}; // Busy flag reads 0 when idle
	endfunction : access_control_reg
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		dcpsp_host_i.frame({OP_WRITE, a, d}, rx);
	endtask : wr
	task automatic rd(input logic [4:0] a);
		dcpsp_host_i.frame({OP_READ, a, 8'h00}, rx);
	endtask : rd
	task automatic settle();
		for (int i = 0; i < NVC + 10 && writeBusy; i++) dcpsp_host_i.cyc(1);
	endtask : settle
	task automatic close_out();
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	initial begin
		#400_000;
		fails++;
		close_out();
	end
	initial begin
		void'($urandom(49336));
		repeat (5) @(posedge mclk);
		#1 rstn = 1'h1;
		`CHK({sdoOeN, standby, writeBusy, shutdownActive}, 4'hc)
		`CHK({wiper0, wiper1}, {WIPER_RESET, WIPER_RESET})
		h0 = dcpsp_host_i.hiCnt;
		rd(ADDR_ACR);
		`CHK(rx, access_control_reg(VOL_RESET, SHUTDOWN_N_BIT_RESET, OUT_RESET))
		`CHK(dcpsp_host_i.hiCnt > h0, 1'h1)
		// Non-volatile write keeps the port awake until done
		v = 8'($urandom);
		wr(ADDR_WIPER0, v);
		dcpsp_host_i.cyc(2);
		`CHK({writeBusy, standby}, 2'h2)
		`CHK(wiper0, v)
		// Busy flag readable; a second write is refused meanwhile
		rd(ADDR_ACR);
		`CHK(rx, access_control_reg(VOL_RESET, SHUTDOWN_N_BIT_RESET, OUT_RESET) | (8'h1 << ACR_WIP))
		wr(ADDR_WIPER0, ~v);
		`CHK({wiper0, writeBusy}, {v, 1'h1})
		settle();
		`CHK({writeBusy, standby}, 2'h1)
		rd(ADDR_WIPER0);
		`CHK(rx, v)
		// General purpose store at a random slot
		gpAddr = 5'(GP_FIRST + $urandom_range(GP_LAST - GP_FIRST));
		gpData = 8'($urandom);
		wr(gpAddr, gpData);
		`CHK(writeBusy, 1'h1)
		settle();
		`CHK({writeBusy, standby}, 2'h1)
		rd(gpAddr);
		`CHK(rx, gpData)
		wr(ADDR_ACR, access_control_reg(1'h1, 1'h1, 1'h0));
		tbl = '{8'hff, 8'h00, 8'($urandom)};
		foreach (tbl[i]) begin
			wr(ADDR_WIPER1, tbl[i]);
			`CHK({wiper1, writeBusy}, {tbl[i], 1'h0})
			rd(ADDR_WIPER1);
			`CHK(rx, tbl[i])
		end
		wr(ADDR_RSVD, 8'h5a);
		`CHK({wiper0, wiper1}, {v, tbl[2]})
		wr(ADDR_ACR, access_control_reg(1'h1, 1'h0, 1'h0));
		`CHK(shutdownActive, 1'h1)
		// Open drain: ones come from the pull-up only
		wr(ADDR_ACR, access_control_reg(1'h1, 1'h1, 1'h1));
		`CHK(shutdownActive, 1'h0)
		h0 = dcpsp_host_i.hiCnt;
		rd(ADDR_ACR);
		`CHK(rx, access_control_reg(1'h1, 1'h1, 1'h1))
		`CHK(dcpsp_host_i.hiCnt, h0)
		// Mid-run reset brings back push-pull and needs a fresh select fall
		@(posedge mclk);
		#1 rstn = 1'h0;
		repeat (5) @(posedge mclk);
		#1 rstn = 1'h1;
		`CHK({sdoOeN, standby, shutdownActive, wiper0}, {3'h6, WIPER_RESET})
		h0 = dcpsp_host_i.hiCnt;
		rd(ADDR_ACR);
		`CHK(rx, access_control_reg(VOL_RESET, SHUTDOWN_N_BIT_RESET, OUT_RESET))
		`CHK(dcpsp_host_i.hiCnt > h0, 1'h1)
		close_out();
	end
endmodule : potentiometer_spi_slave_port_tb_top
